// ==== bench/pci_window0_chipsel_decode_test.sv ====
module pci_window0_chipsel_decode_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        clk_sys;             // 10 MHz bench clock
  logic                        reset;               // sync, active high
  logic                        req_valid;           // address phase request
  logic [pcw0_pkg::ADDR_W-1:0] req_addr;            // its address
  logic [2:0]                  reg_addr;            // software port
  logic [31:0]                 reg_wdata;
  logic                        reg_wr;
  logic                        reg_rd;
  logic [31:0]                 reg_rdata;
  logic                        claim_seen;
  logic [pcw0_pkg::ADDR_W-1:0] window0_base_reg;    // window configuration
  logic [pcw0_pkg::MASK_W-1:0] window0_size_mask;
  logic [pcw0_pkg::PA_W-1:0]   translated_base;
  logic                        window_enable;
  logic                        sg_translate_enable;
  logic                        chipsel_path_enable;
  logic                        hit;
  logic                        hit_via_chipsel;
  logic                        hit_sg;
  logic [pcw0_pkg::PA_W-1:0]   xlat_addr;
  logic [8:0]                  sh_ctrl;             // shadows of what software wrote
  logic [8:0]                  sh_top;
  logic [15:0]                 sh_htop;
  logic [15:0]                 sh_hbot;
  logic [3:0]                  sh_bios;
  logic [31:0]                 rd;                  // read data and scratch
  logic [31:0]                 b;                   // base handed to the window, or value written
  logic [31:0]                 wmask [5] = '{32'h1ff, 32'h1ff, 32'hffff, 32'hffff, 32'hf};
  int                          num_errors = 0;
  int                          checked = 0;
  int                          claims = 0;          // claims expected since reset
  int                          cycles = 0;          // hang guard

  pcw0_link_if link();
  pcw0_dev_end i_pcw0_dev_end (.clk_sys(clk_sys), .reset(reset), .link(link), .window0_base_reg(window0_base_reg),
    .window0_size_mask(window0_size_mask), .translated_base(translated_base), .window_enable(window_enable),
    .sg_translate_enable(sg_translate_enable), .chipsel_path_enable(chipsel_path_enable), .hit(hit),
    .hit_via_chipsel(hit_via_chipsel), .hit_sg(hit_sg), .xlat_addr(xlat_addr));
  pcw0_brg_end i_pcw0_brg_end (.clk_sys(clk_sys), .reset(reset), .link(link), .req_valid(req_valid),
    .req_addr(req_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .claim_seen(claim_seen));
  pcw0_link_asserts i_pcw0_link_asserts (.clk_sys(clk_sys), .reset(reset), .addr_valid(link.addr_valid),
    .addr(link.addr), .chipsel_n(link.chipsel_n), .devsel_n(link.devsel_n),
    .chipsel_path_enable(chipsel_path_enable), .window_enable(window_enable),
    .sg_translate_enable(sg_translate_enable), .window0_base_reg(window0_base_reg),
    .window0_size_mask(window0_size_mask), .hit(hit), .hit_via_chipsel(hit_via_chipsel), .hit_sg(hit_sg));

  // free running clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // the whole run needs about 560 cycles, so 6000 means a hang
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  // compare and count; four-state equality so an unknown never matches
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one write cycle; a gap follows so the strobe is never set twice at one edge
  task automatic reg_write(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    case (a)
      3'h0: sh_ctrl = d[8:0];
      3'h1: sh_top = d[8:0];
      3'h2: sh_htop = d[15:0];
      3'h3: sh_hbot = d[15:0];
      3'h4: sh_bios = d[3:0];
      default: ;
    endcase
  endtask

  // one read cycle; data stand only in the following cycle
  task automatic reg_read(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // select expected from the shadows: hole first, then low, bios and high regions
  function automatic logic exp_sel(input logic [31:0] a);
    logic [31:0] lim;
    lim = (sh_top == 9'h000) ? pcw0_pkg::ONE_MB : {2'b00, sh_top, 21'h000000};
    if (!sh_ctrl[0]) return 1'b0;
    if (sh_hbot <= sh_htop && a[31:16] >= sh_hbot && a[31:16] <= sh_htop) return 1'b0;
    if (a < pcw0_pkg::LOW_LIMIT) return sh_ctrl[4'd1 + a[18:16]];
    if (a >= pcw0_pkg::BIOS_LO && a < pcw0_pkg::ONE_MB) return sh_bios[a[17:16]];
    return a >= pcw0_pkg::ONE_MB && a < lim;
  endfunction

  // direct map splices the address under the mask; sg gives the table entry address
  function automatic logic [32:0] exp_xlat(input logic [31:0] a);
    logic [32:0] lm;
    lm = {1'b0, window0_size_mask, pcw0_pkg::MASK_LOW};
    if (!sg_translate_enable) return (translated_base & ~lm) | ({1'b0, a} & lm);
    return ((translated_base & ~(lm >> 10)) | (({1'b0, a} & lm) >> 10)) & pcw0_pkg::PTE_ALIGN;
  endfunction

  // new window settings, applied at an edge
  task automatic set_cfg(input logic ce, input logic we, input logic sg, input logic [11:0] m, input logic [31:0] bb);
    @(posedge clk_sys);
    chipsel_path_enable <= ce;
    window_enable       <= we;
    sg_translate_enable <= sg;
    window0_size_mask   <= m;
    window0_base_reg    <= bb;
    translated_base     <= 33'({$urandom, $urandom});
  endtask

  // one address phase followed through select, claim and the bridge's echo
  task automatic probe(input logic [31:0] a);
    logic        sel;
    logic        claim;
    logic [32:0] prev;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_addr  <= a;
    sel   = exp_sel(a);
    claim = chipsel_path_enable ? sel
          : window_enable && (((a[31:20] ^ window0_base_reg[31:20]) & ~window0_size_mask) == 12'h000);
    prev  = xlat_addr;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1 check(link.chipsel_n, !sel);
    @(posedge clk_sys);
    #1 check(hit, claim);
    check(link.devsel_n, !claim);
    check(hit_via_chipsel, claim && chipsel_path_enable);
    check(xlat_addr, claim ? exp_xlat(a) : prev);
    check(hit_sg, claim && sg_translate_enable);
    if (claim)
    begin
      claims = claims + 1;
    end
    @(posedge clk_sys);
    #1 check(claim_seen, claim);
  endtask

  // address corners against the current shadows, random elsewhere
  function automatic logic [31:0] pick(input int k);
    logic [31:0] lim;
    lim = {2'b00, sh_top, 21'h000000};
    if (k < 8) return (k << 16) | ($urandom & 32'hfffc);
    if (k < 10) return pcw0_pkg::VGA_LO + ((k - 8) << 16);
    if (k < 14) return pcw0_pkg::BIOS_LO + ((k - 10) << 16) + 32'h40;
    case (k)
      14: return pcw0_pkg::ONE_MB;
      15: return {sh_hbot, 16'h0000};
      16: return {sh_hbot + 16'h0001, 16'hfffc};
      17: return lim - 32'h4;
      18: return lim;
      default: return 32'h2000_0000 | ($urandom & 32'h1fff_fffc);
    endcase
  endfunction

  // main sequence
  initial
  begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_addr = '0;
    reg_addr = 3'h0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    window0_base_reg = '0;
    window0_size_mask = '0;
    translated_base = '0;
    window_enable = 1'b0;
    sg_translate_enable = 1'b0;
    chipsel_path_enable = 1'b0;
    {sh_ctrl, sh_top, sh_htop, sh_hbot, sh_bios} = '0;
    rd = $urandom(57016);
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      reg_read(k[2:0], rd);
      check(rd, 32'h0);
    end
    $display("reset values done");
    // read back every writable field, then the read-only status and the unmapped offset 6
    for (int k = 0; k < 5; k++)
    begin
      // written value kept apart from the read back; top limit stays within 512MB
      b = (k == 1) ? ($urandom & wmask[k]) % 257 : $urandom & wmask[k];
      reg_write(k[2:0], b);
      reg_read(k[2:0], rd);
      check(rd, b);
    end
    reg_write(3'h5, 32'hffff_ffff);
    reg_read(3'h5, rd);
    check(rd[15:0], 16'h0000);
    reg_read(3'h6, rd);
    check(rd, 32'h0);
    $display("register access done");
    // chip select mode; round 2 has no hole, round 3 has decode off
    for (int r = 0; r < 4; r++)
    begin
      reg_write(3'h0, ($urandom & 32'h1fe) | (r != 3));
      reg_write(3'h1, 2 + $urandom % 255);
      reg_write(3'h3, 32'h20);
      reg_write(3'h2, (r == 2) ? 32'h1f : 32'h21);
      reg_write(3'h4, $urandom & 32'hf);
      // window sized to the largest chip select region so translation stays sound
      set_cfg(1'b1, r[0], r[1], 12'h1ff, $urandom);
      for (int k = 0; k < 20; k++)
        probe(pick(k));
      // status remembers the select of the last address phase
      probe(pcw0_pkg::ONE_MB);
      reg_read(3'h5, rd);
      check(rd[16], exp_sel(pcw0_pkg::ONE_MB));
    end
    $display("chip select decode done");
    // base and mask mode, half the addresses aimed inside the window
    for (int k = 0; k < 24; k++)
    begin
      b = $urandom;
      rd = $urandom & 32'h0ff;
      set_cfg(1'b0, k % 4 != 3, k[1], rd[11:0], b);
      probe(k[0] ? b ^ ($urandom & {rd[11:0], 20'hfffff}) : $urandom);
    end
    reg_read(3'h5, rd);
    check(rd[15:0], claims[15:0]);
    $display("base decode and claim count done");
    finish_test();
  end

  // the only place the run ends
  task automatic finish_test();
    $display("compares %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
endmodule

// ==== bench/pcw0_link_asserts.sv ====
module pcw0_link_asserts
(
  input wire logic                        clk_sys,
  input wire logic                        reset,
  input wire logic                        addr_valid,
  input wire logic [pcw0_pkg::ADDR_W-1:0] addr,
  input wire logic                        chipsel_n,
  input wire logic                        devsel_n,
  input wire logic                        chipsel_path_enable,
  input wire logic                        window_enable,
  input wire logic                        sg_translate_enable,
  input wire logic [pcw0_pkg::ADDR_W-1:0] window0_base_reg,
  input wire logic [pcw0_pkg::MASK_W-1:0] window0_size_mask,
  input wire logic                        hit,
  input wire logic                        hit_via_chipsel,
  input wire logic                        hit_sg
);
  // one clock domain, so one default clocking and reset
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ordinary compare, recomputed here so a slip in the window logic shows
  logic base_match;  // window enabled and address inside base and mask
  assign base_match = window_enable && (((addr[31:20] ^ window0_base_reg[31:20]) & ~window0_size_mask) == 12'h000);

  claim_on_select_a: assert property (addr_valid && !chipsel_n && chipsel_path_enable |=> !devsel_n && hit)
    else $error("selected address phase was not claimed");
  enable_override_a: assert property (addr_valid && chipsel_n && chipsel_path_enable |=> devsel_n && !hit)
    else $error("claim without select in chip select mode");
  path_marked_a: assert property (addr_valid |=> hit_via_chipsel == (hit && $past(chipsel_path_enable)))
    else $error("chip select path flag wrong");
  sg_follows_a: assert property (hit |-> hit_sg == $past(sg_translate_enable))
    else $error("translation mode does not follow sg enable");
  base_decode_a: assert property (addr_valid && !chipsel_path_enable |=> hit == $past(base_match))
    else $error("base and mask decode wrong");
  claim_cause_a: assert property (!devsel_n |-> $past(addr_valid) && hit)
    else $error("claim without an address phase");
  vga_hole_a: assert property (addr_valid && addr >= pcw0_pkg::VGA_LO && addr <= pcw0_pkg::VGA_HI |-> chipsel_n)
    else $error("select inside the frame buffer hole");
  top_limit_a: assert property (addr_valid && addr >= 32'h2000_0000 |-> chipsel_n)
    else $error("select above the largest region top");
  select_framed_a: assert property (!addr_valid |-> chipsel_n)
    else $error("select outside an address phase");
endmodule

// ==== rtl/pcw0_brg_end.sv ====
// Function
// - window 0 may take chip select as decode
// - chip select low gives hit and claim
// - sg enable still picks translation mode
// - chip select enable overrides window enable
// - software matches window mask to region size
// - window area covers whole chip select region
// - never select inside the vga hole
// - top limit 2MB steps, 1MB to 512MB; the 9-bit field takes values up to 511, so the logic reaches 1022MB
// - hole bounds in 64KB steps, excluded
// - control enables decode and low regions
// - attribute bits enable bios regions
//
// The register addresses and the strobed register port are this design's own decisions.
module pcw0_brg_end
(
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  pcw0_link_if.brg                         link,
  input  wire logic                        req_valid,
  input  wire logic [pcw0_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [2:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  output logic                             claim_seen
);
  // software programmed decode settings
  logic [pcw0_pkg::LOW_W:0]    chipsel_decode_control;  // enable plus low regions
  logic [pcw0_pkg::TOP_W-1:0]  chipsel_top_limit;       // 2MB units
  logic [pcw0_pkg::HOLE_W-1:0] chipsel_hole_top;        // 64KB units
  logic [pcw0_pkg::HOLE_W-1:0] chipsel_hole_bottom;     // 64KB units
  logic [pcw0_pkg::BIOS_W-1:0] bios_region_attr;        // one bit per bios block
  logic [pcw0_pkg::LOW_W:0]    next_ctrl;
  logic [pcw0_pkg::TOP_W-1:0]  next_top;
  logic [pcw0_pkg::HOLE_W-1:0] next_htop;
  logic [pcw0_pkg::HOLE_W-1:0] next_hbot;
  logic [pcw0_pkg::BIOS_W-1:0] next_bios;

  // software read port
  logic [31:0] next_rdata;

  // link side flops
  logic                        addr_valid;       // address phase strobe
  logic [pcw0_pkg::ADDR_W-1:0] addr;             // address held on the link
  logic                        chipsel_n;        // chip select, active low
  logic                        next_addr_valid;
  logic [pcw0_pkg::ADDR_W-1:0] next_addr;
  logic                        next_chipsel_n;

  // claim observation and status
  logic                        next_claim_seen;
  logic                        last_select;      // chip select of last phase
  logic                        next_last_select;
  logic [pcw0_pkg::STAT_W-1:0] claim_count;      // claims seen since reset
  logic [pcw0_pkg::STAT_W-1:0] next_claim_count;

  // decode intermediates
  logic [pcw0_pkg::ADDR_W-1:0] top_bytes;        // first byte above the region
  logic [pcw0_pkg::ADDR_W-1:0] hole_lo;
  logic [pcw0_pkg::ADDR_W-1:0] hole_hi;
  logic                        in_low;
  logic                        in_vga;
  logic                        in_bios;
  logic                        in_ext;
  logic                        in_hole;
  logic                        region_ok;
  logic                        select;

  // register writes; status is read only, writes to it are dropped
  always_comb
  begin
    next_ctrl = chipsel_decode_control;
    next_top  = chipsel_top_limit;
    next_htop = chipsel_hole_top;
    next_hbot = chipsel_hole_bottom;
    next_bios = bios_region_attr;
    if (reg_wr)
    begin
      case (reg_addr)
        pcw0_pkg::REG_CTRL:
        begin
          next_ctrl = reg_wdata[pcw0_pkg::LOW_W:0];
        end
        pcw0_pkg::REG_TOP:
        begin
          next_top = reg_wdata[pcw0_pkg::TOP_W-1:0];
        end
        pcw0_pkg::REG_HTOP:
        begin
          next_htop = reg_wdata[pcw0_pkg::HOLE_W-1:0];
        end
        pcw0_pkg::REG_HBOT:
        begin
          next_hbot = reg_wdata[pcw0_pkg::HOLE_W-1:0];
        end
        pcw0_pkg::REG_BIOS:
        begin
          next_bios = reg_wdata[pcw0_pkg::BIOS_W-1:0];
        end
        default:
        begin
          // unmapped or read-only offset: nothing stored
          next_ctrl = chipsel_decode_control;
        end
      endcase
    end
  end

  // register storage
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      chipsel_decode_control <= pcw0_pkg::CTRL_RST;
      chipsel_top_limit      <= pcw0_pkg::TOP_RST;
      chipsel_hole_top       <= pcw0_pkg::HOLE_RST;
      chipsel_hole_bottom    <= pcw0_pkg::HOLE_RST;
      bios_region_attr       <= pcw0_pkg::BIOS_RST;
    end
    else
    begin
      chipsel_decode_control <= next_ctrl;
      chipsel_top_limit      <= next_top;
      chipsel_hole_top       <= next_htop;
      chipsel_hole_bottom    <= next_hbot;
      bios_region_attr       <= next_bios;
    end
  end

  // read data one cycle after the strobe; unmapped offsets read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        pcw0_pkg::REG_CTRL: next_rdata = {23'h000000, chipsel_decode_control};
        pcw0_pkg::REG_TOP:  next_rdata = {23'h000000, chipsel_top_limit};
        pcw0_pkg::REG_HTOP: next_rdata = {16'h0000, chipsel_hole_top};
        pcw0_pkg::REG_HBOT: next_rdata = {16'h0000, chipsel_hole_bottom};
        pcw0_pkg::REG_BIOS: next_rdata = {28'h0000000, bios_region_attr};
        pcw0_pkg::REG_STAT: next_rdata = {15'h0000, last_select, claim_count};
        default:            next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read port flop
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // compatibility decode of the incoming request address
  always_comb
  begin
    // a zero limit still gives the least region of 1MB
    if (chipsel_top_limit == '0)
    begin
      top_bytes = pcw0_pkg::ONE_MB;
    end
    else
    begin
      top_bytes = {2'b00, chipsel_top_limit, pcw0_pkg::TOP_PAD};
    end
    hole_lo = {chipsel_hole_bottom, 16'h0000};
    hole_hi = {chipsel_hole_top, 16'hffff};
    in_low  = req_addr < pcw0_pkg::LOW_LIMIT;
    in_vga  = pcw0_pkg::in_range(req_addr, pcw0_pkg::VGA_LO, pcw0_pkg::VGA_HI);
    in_bios = pcw0_pkg::in_range(req_addr, pcw0_pkg::BIOS_LO, pcw0_pkg::ONE_MB - 32'h1);
    in_ext  = (req_addr >= pcw0_pkg::ONE_MB) && (req_addr < top_bytes);
    // an inverted pair of bounds means no hole at all
    in_hole = (chipsel_hole_top >= chipsel_hole_bottom)
              && pcw0_pkg::in_range(req_addr, hole_lo, hole_hi);
    region_ok = 1'b0;
    if (in_low)
    begin
      // each 64KB block below 512KB has its own enable
      region_ok = chipsel_decode_control[pcw0_pkg::CTRL_LOW_LSB + 32'(req_addr[18:16])];
    end
    else if (in_vga)
    begin
      region_ok = 1'b0;
    end
    else if (in_bios)
    begin
      region_ok = bios_region_attr[req_addr[17:16]];
    end
    else if (in_ext)
    begin
      region_ok = 1'b1;
    end
    // hole excluded last, so it also cuts into the low and bios areas
    select = chipsel_decode_control[pcw0_pkg::CTRL_EN_BIT]
             && region_ok && !in_hole;
  end

  // link drive: address and chip select leave together, one cycle after request
  always_comb
  begin
    next_addr_valid  = req_valid;
    next_addr        = req_valid ? req_addr : addr;
    // chip select only asserted during an address phase
    next_chipsel_n   = !(req_valid && select);
    next_last_select = req_valid ? select : last_select;
    // claim seen one cycle after the device drives it
    next_claim_seen  = !link.devsel_n;
    next_claim_count = claim_count + (link.devsel_n ? 16'h0000 : 16'h0001);
  end

  // link and status flops
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      addr_valid  <= 1'b0;
      addr        <= '0;
      chipsel_n   <= 1'b1;
      last_select <= 1'b0;
      claim_seen  <= 1'b0;
      claim_count <= '0;
    end
    else
    begin
      addr_valid  <= next_addr_valid;
      addr        <= next_addr;
      chipsel_n   <= next_chipsel_n;
      last_select <= next_last_select;
      claim_seen  <= next_claim_seen;
      claim_count <= next_claim_count;
    end
  end

  assign link.addr_valid = addr_valid;
  assign link.addr       = addr;
  assign link.chipsel_n  = chipsel_n;
endmodule

// ==== rtl/pcw0_dev_end.sv ====
module pcw0_dev_end
(
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  pcw0_link_if.dev                         link,
  input  wire logic [pcw0_pkg::ADDR_W-1:0] window0_base_reg,
  input  wire logic [pcw0_pkg::MASK_W-1:0] window0_size_mask,
  input  wire logic [pcw0_pkg::PA_W-1:0]   translated_base,
  input  wire logic                        window_enable,
  input  wire logic                        sg_translate_enable,
  input  wire logic                        chipsel_path_enable,
  output logic                             hit,
  output logic                             hit_via_chipsel,
  output logic                             hit_sg,
  output logic      [pcw0_pkg::PA_W-1:0]   xlat_addr
);
  logic [pcw0_pkg::ADDR_W-1:0] cmp_mask;       // address bits that must match base
  logic                        normal_hit;     // base and mask compare result
  logic                        window_hit;     // final window 0 decision
  logic [pcw0_pkg::PA_W-1:0]   xlat_comb;      // translated address, unregistered
  logic                        devsel_n;       // claim flop
  logic                        next_devsel_n;
  logic                        next_hit;
  logic                        next_via;
  logic                        next_sg;
  logic [pcw0_pkg::PA_W-1:0]   next_xlat;

  pcw0_xlat u_xlat
  (
    .addr      (link.addr),
    .size_mask (window0_size_mask),
    .tbase     (translated_base),
    .sg_en     (sg_translate_enable),
    .xlat_addr (xlat_comb)
  );

  // decode: the chip select path overrides both compare and window enable
  always_comb
  begin
    cmp_mask   = ~{window0_size_mask, pcw0_pkg::MASK_LOW};
    normal_hit = window_enable
                 && ((link.addr & cmp_mask) == (window0_base_reg & cmp_mask));
    if (chipsel_path_enable)
    begin
      window_hit = !link.chipsel_n;
    end
    else
    begin
      window_hit = normal_hit;
    end
    next_hit      = link.addr_valid && window_hit;
    next_devsel_n = !next_hit;
    next_via      = next_hit && chipsel_path_enable;
    next_sg       = next_hit && sg_translate_enable;
    // translated address held until the next claim, so it can be read late
    next_xlat     = next_hit ? xlat_comb : xlat_addr;
  end

  // claim and result flops, one cycle after the address phase
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      devsel_n        <= 1'b1;
      hit             <= 1'b0;
      hit_via_chipsel <= 1'b0;
      hit_sg          <= 1'b0;
      xlat_addr       <= '0;
    end
    else
    begin
      devsel_n        <= next_devsel_n;
      hit             <= next_hit;
      hit_via_chipsel <= next_via;
      hit_sg          <= next_sg;
      xlat_addr       <= next_xlat;
    end
  end

  assign link.devsel_n = devsel_n;
endmodule

// ==== rtl/pcw0_link_if.sv ====
interface pcw0_link_if;
  // address phase seen by both ends, one-cycle strobe
  logic                       addr_valid;
  logic [pcw0_pkg::ADDR_W-1:0] addr;
  // compatibility chip select from the eisa bridge, active low
  logic                       chipsel_n;
  // window 0 claims the transaction, active low
  logic                       devsel_n;

  modport dev (input addr_valid, input addr, input chipsel_n, output devsel_n);
  modport brg (output addr_valid, output addr, output chipsel_n, input devsel_n);
endinterface

// ==== rtl/pcw0_pkg.sv ====
package pcw0_pkg;
  // widths of the pci address, window mask field and translated address
  localparam int ADDR_W = 32;
  localparam int MASK_W = 12;
  localparam int PA_W   = 33;
  localparam int LOW_W  = 8;   // one enable per 64KB block below 512KB
  localparam int TOP_W  = 9;   // top limit in 2MB units
  localparam int HOLE_W = 16;  // hole bounds in 64KB units
  localparam int BIOS_W = 4;   // one enable per 64KB bios block
  localparam int STAT_W = 16;

  // controller register offsets on the software port
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_TOP  = 3'h1;
  localparam logic [2:0] REG_HTOP = 3'h2;
  localparam logic [2:0] REG_HBOT = 3'h3;
  localparam logic [2:0] REG_BIOS = 3'h4;
  localparam logic [2:0] REG_STAT = 3'h5;

  // control register field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_LOW_LSB = 1;

  // reset values
  localparam logic [LOW_W:0]    CTRL_RST = 9'h000;
  localparam logic [TOP_W-1:0]  TOP_RST  = 9'h000;
  localparam logic [HOLE_W-1:0] HOLE_RST = 16'h0000;
  localparam logic [BIOS_W-1:0] BIOS_RST = 4'h0;

  // fixed compatibility address map
  localparam logic [ADDR_W-1:0] LOW_LIMIT = 32'h0008_0000;
  localparam logic [ADDR_W-1:0] VGA_LO    = 32'h000a_0000;
  localparam logic [ADDR_W-1:0] VGA_HI    = 32'h000b_ffff;
  localparam logic [ADDR_W-1:0] BIOS_LO   = 32'h000c_0000;
  localparam logic [ADDR_W-1:0] ONE_MB    = 32'h0010_0000;
  localparam logic [20:0]       TOP_PAD   = 21'h000000;

  // window size: mask covers address bits 31:20, below that always inside
  localparam logic [19:0] MASK_LOW = 20'hfffff;
  localparam int          SG_SHIFT = 10;  // pte address = page index * 8
  localparam logic [PA_W-1:0] PTE_ALIGN = 33'h1_ffff_fff8;

  // inclusive range test used by several decoders
  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction
endpackage

// ==== rtl/pcw0_xlat.sv ====
module pcw0_xlat
(
  input  wire logic [pcw0_pkg::ADDR_W-1:0] addr,
  input  wire logic [pcw0_pkg::MASK_W-1:0] size_mask,
  input  wire logic [pcw0_pkg::PA_W-1:0]   tbase,
  input  wire logic                        sg_en,
  output logic      [pcw0_pkg::PA_W-1:0]   xlat_addr
);
  logic [pcw0_pkg::PA_W-1:0] low_mask;  // bytes inside the window
  logic [pcw0_pkg::PA_W-1:0] pte_mask;  // bytes of the map table
  logic [pcw0_pkg::PA_W-1:0] addr_ext;  // address widened to memory space

  // translation is purely combinational; the end registers the result
  always_comb
  begin
    low_mask = {1'b0, size_mask, pcw0_pkg::MASK_LOW};
    pte_mask = low_mask >> pcw0_pkg::SG_SHIFT;
    addr_ext = {1'b0, addr};
    if (sg_en)
    begin
      // map table entry: base bits above the table size, page index * 8
      xlat_addr = ((tbase & ~pte_mask) | ((addr_ext & low_mask) >> pcw0_pkg::SG_SHIFT))
                  & pcw0_pkg::PTE_ALIGN;
    end
    else
    begin
      // direct map: base replaces the bits above the window size
      xlat_addr = (tbase & ~low_mask) | (addr_ext & low_mask);
    end
  end
endmodule
